// ### local_switch_config_ctrl.sv
// front-panel rotary, paddle and button configuration controller
//
// The implementer's own choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "lsc_consts.svh"
module local_switch_config_ctrl #(
    parameter int TICK_CYC = `TICK_CYC,
    parameter int HOLD_TICKS = `HOLD_TICKS,
    parameter int REP_TICKS = `REP_TICKS
) (
    input wire logic REF_CLK,
    input wire logic RST_B,
    input wire logic [3:0] FUNCTION_SELECTOR,
    input wire logic PADDLE_SWITCH_UP,
    input wire logic PADDLE_SWITCH_DOWN,
    input wire logic MODE_TOGGLE_BUTTON,
    input wire logic [3:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [7:0] REG_RDATA,
    output logic BANK_INDICATOR,
    output logic CHANNEL_SELECT_INDICATOR,
    output logic CHANNEL_CODE_LED_HIGH,
    output logic CHANNEL_CODE_LED_LOW,
    output logic CONFIGURING_INDICATOR,
    output var lsc_pkg::chan_cfg_t [`NUM_CH-1:0] CHAN_CFG
);
    import lsc_pkg::*;

    localparam int TW = $clog2(TICK_CYC);
    localparam int FW = $clog2(`FLASH_TICKS);
    localparam int CW = $clog2(`INIT_TICKS + 1);

    logic [TW-1:0] tick_cnt_r;
    logic tick_r;
    logic [FW-1:0] flash_cnt_r;
    logic flash_r;
    logic [3:0] pos_r;
    logic wrap_fwd;
    logic wrap_bwd;
    bank_t bank_r;
    bank_t bank_nxt;
    pmode_t mode_r;
    logic btn_r;
    logic press;
    logic lock_r;
    logic [1:0] chan_r;
    logic step_up;
    logic step_dn;
    logic act;
    logic accel_en;
    logic hit_gain;
    logic hit_mono;
    logic hit_frz;
    logic applied;
    logic [CW-1:0] configuring_indicator_cnt_r;
    chan_cfg_t [`NUM_CH-1:0] cfg_r;
    logic [7:0] rdata_nxt;

    // one-millisecond enable; all slow timing counts these ticks
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            tick_cnt_r <= '0;
            tick_r <= 1'b0;
        end else begin
            tick_r <= (tick_cnt_r == TW'(TICK_CYC - 1));
            if (tick_cnt_r == TW'(TICK_CYC - 1)) begin
                tick_cnt_r <= '0;
            end else begin
                tick_cnt_r <= tick_cnt_r + TW'(1);
            end
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            flash_cnt_r <= '0;
            flash_r <= 1'b0;
        end else if (tick_r) begin
            if (flash_cnt_r == FW'(`FLASH_TICKS - 1)) begin
                flash_cnt_r <= '0;
                flash_r <= ~flash_r;
            end else begin
                flash_cnt_r <= flash_cnt_r + FW'(1);
            end
        end
    end

    // selector position and bank; a detent jump between F and 0 marks a full turn
    assign wrap_fwd = (pos_r == `POS_LAST) && (FUNCTION_SELECTOR == `POS_PARK);
    assign wrap_bwd = (pos_r == `POS_PARK) && (FUNCTION_SELECTOR == `POS_LAST);

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            pos_r <= `POS_PARK;
        end else begin
            pos_r <= FUNCTION_SELECTOR;
        end
    end

    always_comb begin
        bank_nxt = bank_r;
        case (bank_r)
            BANK1: begin
                if (wrap_fwd) begin
                    bank_nxt = BANK2;
                end
            end
            BANK2: begin
                if (wrap_fwd) begin
                    bank_nxt = BANK3;
                end else if (wrap_bwd) begin
                    bank_nxt = BANK1;
                end
            end
            BANK3: begin
                if (wrap_bwd) begin
                    bank_nxt = BANK2;
                end
            end
            default: bank_nxt = BANK1;
        endcase
    end

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            bank_r <= BANK1;
        end else begin
            bank_r <= bank_nxt;
        end
    end

    // mode button; lock from software blocks the button and the paddle, while the selector still steps the bank
    assign press = MODE_TOGGLE_BUTTON & ~btn_r & ~lock_r;

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            btn_r <= 1'b0;
        end else begin
            btn_r <= MODE_TOGGLE_BUTTON;
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            mode_r <= PARAM;
        end else if (press) begin
            case (mode_r)
                PARAM: mode_r <= CHSEL;
                CHSEL: mode_r <= PARAM;
                default: mode_r <= PARAM;
            endcase
        end
    end

    // only the gain parameter has 256 values, so only it accelerates
    assign accel_en = (mode_r == PARAM) && (bank_r == BANK1) && (pos_r == `POS_GAIN);

    paddle_repeat #(
        .HOLD_TICKS(HOLD_TICKS),
        .REP_TICKS(REP_TICKS)
    ) u_paddle (
        .clk(REF_CLK),
        .rst_b(RST_B),
        .tick(tick_r),
        .up(PADDLE_SWITCH_UP & ~lock_r),
        .dn(PADDLE_SWITCH_DOWN & ~lock_r),
        .accel_en(accel_en),
        .step_up(step_up),
        .step_dn(step_dn)
    );

    assign act = step_up | step_dn;

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            chan_r <= 2'h0;
        end else if (act && mode_r == CHSEL) begin
            if (step_up) begin
                chan_r <= chan_r + 2'h1;
            end else begin
                chan_r <= chan_r - 2'h1;
            end
        end
    end

    // position 0 matches none of these, so a parked selector edits nothing
    assign hit_gain = (bank_r == BANK1) && (pos_r == `POS_GAIN);
    assign hit_mono = (bank_r == BANK2) && (pos_r == `POS_MONO);
    assign hit_frz = (bank_r == BANK3) && (pos_r >= `POS_FRZ_LO)
        && (pos_r <= `POS_FRZ_HI);
    assign applied = act && ((mode_r == CHSEL) || hit_gain || hit_mono || hit_frz);

    genvar g;
    generate
        for (g = 0; g < `NUM_CH; g++) begin : g_chan
            always_ff @(posedge REF_CLK or negedge RST_B) begin
                if (!RST_B) begin
                    cfg_r[g].freeze <= FRZ_NONE;
                    cfg_r[g].mono <= 1'b0;
                    cfg_r[g].gain <= `GAIN_RST;
                end else if (act && mode_r == PARAM && chan_r == 2'(g)) begin
                    if (hit_gain && step_up && cfg_r[g].gain != `GAIN_MAX) begin
                        cfg_r[g].gain <= cfg_r[g].gain + 8'h01;
                    end
                    if (hit_gain && step_dn && cfg_r[g].gain != `GAIN_MIN) begin
                        cfg_r[g].gain <= cfg_r[g].gain - 8'h01;
                    end
                    if (hit_mono) begin
                        cfg_r[g].mono <= step_up;
                    end
                    if (hit_frz && step_up && cfg_r[g].freeze != FRZ_FRAME) begin
                        cfg_r[g].freeze <= freeze_t'(cfg_r[g].freeze + 3'h1);
                    end
                    if (hit_frz && step_dn && cfg_r[g].freeze != FRZ_NONE) begin
                        cfg_r[g].freeze <= freeze_t'(cfg_r[g].freeze - 3'h1);
                    end
                end
            end
        end
    endgenerate

    // configuring window: opens at reset and again for each applied change
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            configuring_indicator_cnt_r <= CW'(`INIT_TICKS);
        end else if (applied) begin
            configuring_indicator_cnt_r <= CW'(`CONFIGURING_INDICATOR_TICKS);
        end else if (tick_r && configuring_indicator_cnt_r != '0) begin
            configuring_indicator_cnt_r <= configuring_indicator_cnt_r - CW'(1);
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            lock_r <= 1'b0;
        end else if (REG_WR && REG_ADDR == `REG_CTRL) begin
            lock_r <= REG_WDATA[0];
        end
    end

    // indicators all registered
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            BANK_INDICATOR <= 1'b0;
            CHANNEL_SELECT_INDICATOR <= 1'b0;
            CHANNEL_CODE_LED_HIGH <= 1'b0;
            CHANNEL_CODE_LED_LOW <= 1'b0;
            CONFIGURING_INDICATOR <= 1'b1;
        end else begin
            BANK_INDICATOR <= (bank_r == BANK2) || (bank_r == BANK3 && flash_r);
            CHANNEL_SELECT_INDICATOR <= (mode_r == CHSEL);
            CHANNEL_CODE_LED_HIGH <= chan_r[1];
            CHANNEL_CODE_LED_LOW <= chan_r[0];
            CONFIGURING_INDICATOR <= (configuring_indicator_cnt_r != '0);
        end
    end

    assign CHAN_CFG = cfg_r;

    always_comb begin
        rdata_nxt = 8'h00;
        case (REG_ADDR)
            `REG_STATUS: rdata_nxt = {2'h0, (configuring_indicator_cnt_r != '0), (mode_r == CHSEL),
                (bank_r == BANK3), (bank_r == BANK2), chan_r};
            `REG_CTRL: rdata_nxt = {7'h00, lock_r};
            default: begin
                if (REG_ADDR[3:2] == 2'(`REG_CFG0 >> 2)) begin
                    rdata_nxt = {4'h0, cfg_r[REG_ADDR[1:0]].freeze, cfg_r[REG_ADDR[1:0]].mono};
                end else if (REG_ADDR[3:2] == 2'(`REG_GAIN0 >> 2)) begin
                    rdata_nxt = cfg_r[REG_ADDR[1:0]].gain;
                end
            end
        endcase
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            REG_RDATA <= 8'h00;
        end else if (REG_RD) begin
            REG_RDATA <= rdata_nxt;
        end else begin
            REG_RDATA <= 8'h00;
        end
    end

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RST_B);

    // panel checks; every led is one register stage behind the state it shows
    AST_BANK_UP: assert property (wrap_fwd && bank_r == BANK1 |=> bank_r == BANK2)
        else $error("forward turn did not reach bank 2");
    AST_BANK_DOWN_FLOOR: assert property (wrap_bwd && bank_r == BANK1
        |=> bank_r == BANK1)
        else $error("bank fell below bank 1");
    AST_BANK_DOWN: assert property (wrap_bwd && bank_r == BANK3 |=> bank_r == BANK2)
        else $error("reverse turn did not step bank down");
    AST_BANK_LED: assert property (bank_r == BANK1 ##1 bank_r == BANK1
        |=> !BANK_INDICATOR)
        else $error("bank indicator lit in bank 1");
    AST_BANK2_LED: assert property (bank_r == BANK2 |=> BANK_INDICATOR)
        else $error("bank indicator dark in bank 2");
    AST_CSEL_LED: assert property (1'b1 |=>
        CHANNEL_SELECT_INDICATOR == ($past(mode_r) == CHSEL))
        else $error("channel select indicator does not follow mode");
    AST_MODE_TOGGLE: assert property (press |=> mode_r != $past(mode_r) ##1
        CHANNEL_SELECT_INDICATOR == (mode_r == CHSEL))
        else $error("mode press not reflected");
    AST_CHAN_WRAP: assert property (step_up && mode_r == CHSEL && chan_r == 2'h3
        |=> chan_r == 2'h0)
        else $error("channel did not wrap to first");
    AST_CHAN_STEP_UP: assert property (step_up && mode_r == CHSEL
        |=> chan_r == $past(chan_r) + 2'h1)
        else $error("channel did not step up");
    AST_CHAN_STEP_DN: assert property (step_dn && mode_r == CHSEL && chan_r == 2'h0
        |=> chan_r == 2'h3)
        else $error("channel did not wrap to last");
    AST_CHAN_CODE: assert property (1'b1 |=> {CHANNEL_CODE_LED_HIGH, CHANNEL_CODE_LED_LOW}
        == $past(chan_r))
        else $error("channel code leds mismatch");
    AST_PARKED: assert property (pos_r == `POS_PARK |=> cfg_r == $past(cfg_r))
        else $error("setting changed at parked position");
    AST_OTHER_CHAN: assert property (chan_r != 2'h0 |=> cfg_r[0] == $past(cfg_r[0]))
        else $error("inactive channel setting changed");
    AST_MONO_ON: assert property (step_up && mode_r == PARAM && hit_mono
        && chan_r == 2'h1 |=> cfg_r[1].mono)
        else $error("monochrome flag not set");
    AST_MONO_OFF: assert property (step_dn && mode_r == PARAM && hit_mono
        && chan_r == 2'h1 |=> !cfg_r[1].mono)
        else $error("monochrome flag not cleared");
    AST_FRZ_SAT: assert property (step_up && mode_r == PARAM && hit_frz
        && chan_r == 2'h1 && cfg_r[1].freeze == FRZ_FRAME |=> cfg_r[1].freeze == FRZ_FRAME)
        else $error("freeze mode stepped past frame");
    AST_CONFIGURING_INDICATOR_LED: assert property (applied |=> ##1 CONFIGURING_INDICATOR)
        else $error("configuring indicator not lit after change");
    AST_CONFIGURING_INDICATOR_IDLE: assert property (configuring_indicator_cnt_r == CW'(0) |=> !CONFIGURING_INDICATOR)
        else $error("configuring indicator lit with window closed");
    AST_RDATA_IDLE: assert property (!REG_RD |=> REG_RDATA == 8'h00)
        else $error("read data present without a read");
endmodule : local_switch_config_ctrl
`default_nettype wire

// ### lsc_consts.svh
// timing counts, positions, reset values and register offsets for the local switch controller
`ifndef LSC_CONSTS_SVH
`define LSC_CONSTS_SVH
`define CLK_KHZ 25000
`define TICK_US 1000
`define TICK_CYC (`TICK_US * `CLK_KHZ / 1000)
`define HOLD_MS 500
`define HOLD_TICKS (`HOLD_MS * 1000 / `TICK_US)
`define RANGE_MS 10000
`define ACCEL_STEPS 256
`define REP_TICKS (`RANGE_MS * 1000 / `TICK_US / `ACCEL_STEPS)
`define FLASH_TICKS (500 * 1000 / `TICK_US)
`define INIT_TICKS (100 * 1000 / `TICK_US)
`define CONFIGURING_INDICATOR_TICKS (50 * 1000 / `TICK_US)
`define NUM_CH 4
`define POS_PARK 4'h0
`define POS_LAST 4'hF
`define POS_GAIN 4'h4
`define POS_MONO 4'hA
`define POS_FRZ_LO 4'h2
`define POS_FRZ_HI 4'h4
`define GAIN_RST 8'h37
`define GAIN_MAX 8'hFF
`define GAIN_MIN 8'h00
`define REG_STATUS 4'h0
`define REG_CTRL 4'h1
`define REG_CFG0 4'h4
`define REG_GAIN0 4'h8
`endif

// ### lsc_pkg.sv
// types shared by the local switch controller
package lsc_pkg;
    typedef enum logic [2:0] {BANK1 = 3'b001, BANK2 = 3'b010, BANK3 = 3'b100} bank_t;
    typedef enum logic [1:0] {PARAM = 2'b01, CHSEL = 2'b10} pmode_t;
    typedef enum logic [2:0] {
        FRZ_NONE = 3'h0, FRZ_AUTO = 3'h1, FRZ_BLUE = 3'h2,
        FRZ_FLD1 = 3'h3, FRZ_FLD2 = 3'h4, FRZ_FRAME = 3'h5
    } freeze_t;
    typedef struct packed {
        freeze_t freeze;
        logic mono;
        logic [7:0] gain;
    } chan_cfg_t;
endpackage : lsc_pkg

// ### paddle_repeat.sv
// paddle press detector with hold-to-accelerate repeat
`timescale 1ns/1ps
`default_nettype none
`include "lsc_consts.svh"
module paddle_repeat #(
    parameter int HOLD_TICKS = `HOLD_TICKS,
    parameter int REP_TICKS = `REP_TICKS
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic tick,
    input wire logic up,
    input wire logic dn,
    input wire logic accel_en,
    output logic step_up,
    output logic step_dn
);
    localparam int HW = $clog2(HOLD_TICKS + 1);
    localparam int RW = $clog2(REP_TICKS + 1);
    logic [1:0] dir;
    logic [1:0] dir_r;
    logic [HW-1:0] hold_r;
    logic [RW-1:0] rep_r;
    logic held;
    logic rep_fire;

    // both directions at once is treated as released
    assign dir = {dn & ~up, up & ~dn};
    assign held = (dir != 2'h0) && (dir == dir_r);
    assign rep_fire = held && accel_en && tick && (hold_r == HW'(HOLD_TICKS))
        && (rep_r == RW'(REP_TICKS - 1));

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            dir_r <= 2'h0;
        end else begin
            dir_r <= dir;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            hold_r <= '0;
            rep_r <= '0;
        end else if (!held) begin
            hold_r <= '0;
            rep_r <= '0;
        end else if (tick) begin
            if (hold_r != HW'(HOLD_TICKS)) begin
                hold_r <= hold_r + HW'(1);
            end else if (rep_fire) begin
                rep_r <= '0;
            end else begin
                rep_r <= rep_r + RW'(1);
            end
        end
    end

    // one step per fresh press, then steady repeat once held past the hold time
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            step_up <= 1'b0;
            step_dn <= 1'b0;
        end else begin
            step_up <= dir[0] & ((dir != dir_r) | rep_fire);
            step_dn <= dir[1] & ((dir != dir_r) | rep_fire);
        end
    end

    AST_STEP_ONE_CYCLE: assert property (@(posedge clk) disable iff (!rst_b)
        step_up && !rep_fire |=> !step_up)
        else $error("paddle step longer than one cycle");
endmodule : paddle_repeat
`default_nettype wire

// ### panel_operator.sv
// behavioural operator at the front panel: rotary, paddle and button
`timescale 1ns/1ps
`default_nettype none
module panel_operator (
    input wire logic clk,
    output logic [3:0] sel,
    output logic up,
    output logic dn,
    output logic btn
);
    initial begin
        sel = 4'h0;
        up = 1'b0;
        dn = 1'b0;
        btn = 1'b0;
    end
    // settle long enough for the bank indicator to follow
    task automatic turn(input logic [3:0] p);
        @(posedge clk);
        sel <= p;
        repeat (4) @(posedge clk);
        #1;
    endtask : turn
    // a short hold is one step, a long hold exercises repeat
    task automatic flick(input logic is_up, input int held);
        @(posedge clk);
        up <= is_up;
        dn <= !is_up;
        repeat (held) @(posedge clk);
        up <= 1'b0;
        dn <= 1'b0;
        repeat (6) @(posedge clk);
        #1;
    endtask : flick
    task automatic press();
        @(posedge clk);
        btn <= 1'b1;
        repeat (3) @(posedge clk);
        btn <= 1'b0;
        repeat (4) @(posedge clk);
        #1;
    endtask : press
endmodule : panel_operator
`default_nettype wire

// ### tb_local_switch_config_ctrl.sv
// self-checking bench for the local switch controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin fail_count++; \
    $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module tb_local_switch_config_ctrl;
    import lsc_pkg::*;
    localparam int TCYC = 4;
    localparam int LIMIT = 12000;
    logic ref_clk = 1'b0;
    logic rst_b;
    logic [3:0] sel;
    logic up;
    logic dn;
    logic btn;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [7:0] reg_rdata;
    logic bank_led;
    logic csel_led;
    logic code_hi;
    logic code_lo;
    logic configuring_indicator_led;
    chan_cfg_t [3:0] chan_cfg;
    int fail_count = 0;
    int samples_checked = 0;
    int cycles = 0;
    int n;
    logic last;

    always #20 ref_clk = ~ref_clk;

    // short ticks keep the init, flash and repeat counts affordable
    local_switch_config_ctrl #(.TICK_CYC(TCYC), .HOLD_TICKS(3), .REP_TICKS(2))
        u_local_switch_config_ctrl (
        .REF_CLK(ref_clk), .RST_B(rst_b), .FUNCTION_SELECTOR(sel),
        .PADDLE_SWITCH_UP(up), .PADDLE_SWITCH_DOWN(dn), .MODE_TOGGLE_BUTTON(btn),
        .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
        .REG_RDATA(reg_rdata), .BANK_INDICATOR(bank_led),
        .CHANNEL_SELECT_INDICATOR(csel_led), .CHANNEL_CODE_LED_HIGH(code_hi),
        .CHANNEL_CODE_LED_LOW(code_lo), .CONFIGURING_INDICATOR(configuring_indicator_led),
        .CHAN_CFG(chan_cfg)
    );
    panel_operator u_panel_operator (
        .clk(ref_clk), .sel(sel), .up(up), .dn(dn), .btn(btn)
    );

    task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : reg_write
    // read data stands only in the cycle after the strobe
    task automatic reg_read(input logic [3:0] a, input logic [7:0] e, input string nm);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        `CHK(nm, e, reg_rdata)
    endtask : reg_read

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : end_of_test

    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            fail_count++;
            end_of_test();
        end
    end

    initial begin
        rst_b = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        repeat (12) @(posedge ref_clk);
        `CHK("configuring_indicator_in_reset", 1'b1, configuring_indicator_led)
        `CHK("cfg_reset", {4{12'h037}}, chan_cfg)
        rst_b <= 1'b1;
        repeat (390) @(posedge ref_clk);
        #1;
        `CHK("configuring_indicator_init", 1'b1, configuring_indicator_led)
        repeat (30) @(posedge ref_clk);
        #1;
        `CHK("configuring_indicator_done", 1'b0, configuring_indicator_led)
        `CHK("bank1_led", 1'b0, bank_led)
        u_panel_operator.flick(1'b1, 4);
        `CHK("park_cfg", {4{12'h037}}, chan_cfg)
        `CHK("park_configuring_indicator", 1'b0, configuring_indicator_led)
        u_panel_operator.turn(4'h4);
        u_panel_operator.flick(1'b1, 4);
        `CHK("gain_up", 8'h38, chan_cfg[0].gain)
        `CHK("configuring_indicator_step", 1'b1, configuring_indicator_led)
        u_panel_operator.flick(1'b0, 4);
        `CHK("gain_dn", 8'h37, chan_cfg[0].gain)
        u_panel_operator.flick(1'b1, 60);
        `CHK("accel", 1'b1, chan_cfg[0].gain > 8'h39)
        `CHK("other_ch", 12'h037, chan_cfg[1])
        u_panel_operator.press();
        `CHK("csel_on", 1'b1, csel_led)
        for (int k = 1; k <= 4; k++) begin
            u_panel_operator.flick(1'b1, 4);
            `CHK("chan_code", 2'(k % 4), {code_hi, code_lo})
        end
        u_panel_operator.flick(1'b0, 4);
        `CHK("chan_wrap_dn", 2'h3, {code_hi, code_lo})
        u_panel_operator.flick(1'b1, 4);
        u_panel_operator.flick(1'b1, 4);
        `CHK("chan_cfg_kept", 12'h037, chan_cfg[1])
        u_panel_operator.press();
        `CHK("csel_off", 1'b0, csel_led)
        u_panel_operator.turn(4'hF);
        u_panel_operator.turn(4'h0);
        `CHK("bank2_led", 1'b1, bank_led)
        u_panel_operator.turn(4'hA);
        u_panel_operator.flick(1'b1, 4);
        `CHK("mono_on", 1'b1, chan_cfg[1].mono)
        `CHK("mono_ch0", 1'b0, chan_cfg[0].mono)
        u_panel_operator.flick(1'b0, 4);
        `CHK("mono_off", 1'b0, chan_cfg[1].mono)
        u_panel_operator.flick(1'b1, 4);
        u_panel_operator.turn(4'hF);
        u_panel_operator.turn(4'h0);
        for (int k = 1; k <= 6; k++) begin
            u_panel_operator.turn(4'(2 + k % 3));
            u_panel_operator.flick(1'b1, 4);
            `CHK("freeze_up", 3'((k > 5) ? 5 : k), chan_cfg[1].freeze)
        end
        // lock holds the paddle and button off while software owns the settings
        reg_write(4'h1, 8'h01);
        reg_read(4'h1, 8'h01, "ctrl");
        u_panel_operator.flick(1'b0, 4);
        `CHK("locked", 3'h5, chan_cfg[1].freeze)
        reg_write(4'h1, 8'h00);
        u_panel_operator.flick(1'b0, 4);
        `CHK("freeze_dn", 3'h4, chan_cfg[1].freeze)
        repeat (210) @(posedge ref_clk);
        reg_read(4'h0, 8'h09, "status");
        reg_read(4'h5, 8'h09, "cfg1");
        reg_read(4'h9, 8'h37, "gain1");
        reg_read(4'hC, 8'h00, "unmapped");
        n = 0;
        last = bank_led;
        repeat (4100) begin
            @(posedge ref_clk);
            #1;
            if (bank_led !== last) n++;
            last = bank_led;
        end
        `CHK("flash", 1'b1, n >= 2 && n <= 3)
        u_panel_operator.turn(4'h0);
        u_panel_operator.turn(4'hF);
        `CHK("rev_bank2", 1'b1, bank_led)
        reg_read(4'h0, 8'h05, "status_b2");
        // a reverse turn must sweep down through 0 and back to F, never F to 0
        for (int k = 0; k < 2; k++) begin
            u_panel_operator.turn(4'h8);
            u_panel_operator.turn(4'h0);
            u_panel_operator.turn(4'hF);
            `CHK("rev_bank1", 1'b0, bank_led)
        end
        `CHK("rev_floor", 1'b0, bank_led)
        reg_read(4'h0, 8'h01, "status_b1");
        end_of_test();
    end
endmodule : tb_local_switch_config_ctrl
`default_nettype wire
